// ### src/fscs_fail_safe_clock_supervisor.sv
// fail-safe clock supervisor with its wishbone register slave
`timescale 1ns/1ps
module fscs_fail_safe_clock_supervisor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic deviceClock,
  input wire logic internalRcClock,
  input wire logic monitorEnableConfigBit,
  input wire logic watchdogEnable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fscs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic clkSelInternal,
  output logic oscFailIrq,
  output logic watchdogReset,
  output logic rcRunRequest,
  output logic [1:0] oscSourceSelect,
  output logic [2:0] internalOscFreqSelect
);

  fscs_pkg::fscs_state_s s_q;
  fscs_pkg::fscs_state_s s_d;

  logic rcRise;
  logic sampleRise;
  logic sampleFall;
  logic devFall;
  logic watchable;
  logic failure;
  logic busReq;
  logic wrLane0;
  logic pmEnter;
  logic [31:0] rdMux;

  // one decode for every register write strobe
  function automatic logic regWrite(input logic strobe, input logic [fscs_pkg::ADR_W-1:0] adr,
                                    input logic [fscs_pkg::ADR_W-1:0] ofs);
    return strobe && (adr == ofs);
  endfunction

  always_comb begin
    s_d = s_q;

    // ----------------------------------------------------------------
    // sample clock, counted on rc rising edges
    // ----------------------------------------------------------------
    // inputs are synchronous to clk, so one previous-value flop suffices for edge finding
    rcRise = internalRcClock && !s_q.rcPrev;
    devFall = !deviceClock && s_q.devPrev;
    sampleRise = rcRise && (s_q.divCnt == fscs_pkg::DIV_HALF_LAST); // [RQ3]
    sampleFall = rcRise && (s_q.divCnt == fscs_pkg::DIV_LAST); // [RQ3]
    s_d.rcPrev = internalRcClock;
    s_d.devPrev = deviceClock;
    if (rcRise) begin
      s_d.divCnt = s_q.divCnt + 1'b1; // [RQ3]
    end

    // ----------------------------------------------------------------
    // monitor latch and failure test
    // ----------------------------------------------------------------
    // a device edge in the same cycle as the sample rise wins, so a live clock is never missed
    if (devFall) begin
      s_d.monLatch = 1'b1; // [RQ4]
    end else if (sampleRise) begin
      s_d.monLatch = 1'b0; // [RQ4]
    end

    // the internal oscillator cannot be watched by itself
    watchable = (s_q.srcSelect == fscs_pkg::SRC_PRIMARY)
             || (s_q.srcSelect == fscs_pkg::SRC_SECONDARY); // [RQ9]
    failure = (s_q.mode == fscs_pkg::FSCS_WATCH) && watchable && sampleFall && s_q.monLatch; // [RQ5]

    // ----------------------------------------------------------------
    // wishbone decode
    // ----------------------------------------------------------------
    busReq = wb_cyc_i && wb_stb_i && !s_q.ack;
    wrLane0 = busReq && wb_we_i && wb_sel_i[0];
    pmEnter = regWrite(wrLane0, wb_adr_i, fscs_pkg::OFS_POWER_MANAGE) && wb_dat_i[fscs_pkg::BIT_PM_ENTER];

    // ----------------------------------------------------------------
    // supervisor mode
    // ----------------------------------------------------------------
    case (s_q.mode)
      fscs_pkg::FSCS_IDLE: begin
        if (monitorEnableConfigBit) begin
          s_d.mode = fscs_pkg::FSCS_WATCH; // [RQ1]
        end
      end
      fscs_pkg::FSCS_WATCH: begin
        if (!monitorEnableConfigBit) begin
          s_d.mode = fscs_pkg::FSCS_IDLE; // [RQ1]
        end else if (failure) begin
          s_d.mode = fscs_pkg::FSCS_FAILSAFE; // [RQ7]
        end
      end
      fscs_pkg::FSCS_FAILSAFE: begin
        // held here until a power-managed mode is entered or the device resets
        if (pmEnter) begin
          s_d.mode = fscs_pkg::FSCS_IDLE; // [RQ12]
        end
      end
      default: begin
        s_d.mode = fscs_pkg::FSCS_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (regWrite(wrLane0, wb_adr_i, fscs_pkg::OFS_IRQ_ENABLE_2)) begin
      s_d.oscFailEnable = wb_dat_i[fscs_pkg::BIT_OSC_FAIL];
    end
    if (regWrite(wrLane0, wb_adr_i, fscs_pkg::OFS_OSC_CONTROL)) begin
      s_d.freqSelect = wb_dat_i[fscs_pkg::POS_FREQ_HI:fscs_pkg::POS_FREQ_LO];
      s_d.srcSelect = wb_dat_i[fscs_pkg::POS_SRC_HI:fscs_pkg::POS_SRC_LO];
    end
    // write one to clear; a failure in the same cycle keeps the flag set
    if (regWrite(wrLane0, wb_adr_i, fscs_pkg::OFS_IRQ_FLAGS_2) && wb_dat_i[fscs_pkg::BIT_OSC_FAIL]) begin
      s_d.oscFailFlag = 1'b0; // [RQ13]
    end
    if (failure) begin
      s_d.oscFailFlag = 1'b1; // [RQ6]
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    rdMux = 32'h0000_0000;
    case (wb_adr_i)
      fscs_pkg::OFS_IRQ_FLAGS_2: begin
        rdMux[fscs_pkg::BIT_OSC_FAIL] = s_q.oscFailFlag;
      end
      fscs_pkg::OFS_IRQ_ENABLE_2: begin
        rdMux[fscs_pkg::BIT_OSC_FAIL] = s_q.oscFailEnable;
      end
      fscs_pkg::OFS_OSC_CONTROL: begin
        // the source field keeps the software value even in fail-safe
        rdMux[fscs_pkg::POS_FREQ_HI:fscs_pkg::POS_FREQ_LO] = s_q.freqSelect; // [RQ7]
        rdMux[fscs_pkg::POS_SRC_HI:fscs_pkg::POS_SRC_LO] = s_q.srcSelect; // [RQ7]
      end
      fscs_pkg::OFS_STATUS: begin
        rdMux[fscs_pkg::BIT_ST_FAILSAFE] = (s_q.mode == fscs_pkg::FSCS_FAILSAFE);
        rdMux[fscs_pkg::BIT_ST_LATCH] = s_q.monLatch;
        rdMux[fscs_pkg::BIT_ST_ACTIVE] = (s_q.mode == fscs_pkg::FSCS_WATCH);
        rdMux[fscs_pkg::BIT_ST_SAMPLE] = s_q.divCnt[fscs_pkg::DIV_W-1];
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
    s_d.ack = busReq;
    s_d.rdData = (busReq && !wb_we_i) ? rdMux : 32'h0000_0000;

    // ----------------------------------------------------------------
    // outputs, all registered
    // ----------------------------------------------------------------
    s_d.clkSelInternal = (s_d.mode == fscs_pkg::FSCS_FAILSAFE)
                      || (s_d.srcSelect == fscs_pkg::SRC_INTERNAL); // [RQ7]
    s_d.irq = s_d.oscFailFlag && s_d.oscFailEnable; // [RQ13]
    s_d.wdtReset = failure; // [RQ8]
    // the watchdog's own divider does not gate the rc clock request
    s_d.rcRun = monitorEnableConfigBit || watchdogEnable; // [RQ2] [RQ10]
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.mode <= fscs_pkg::FSCS_IDLE;
      s_q.srcSelect <= fscs_pkg::RST_SRC;
      s_q.freqSelect <= fscs_pkg::RST_FREQ;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdData;
  assign wb_ack_o = s_q.ack;
  assign clkSelInternal = s_q.clkSelInternal;
  assign oscFailIrq = s_q.irq;
  assign watchdogReset = s_q.wdtReset;
  assign rcRunRequest = s_q.rcRun;
  assign oscSourceSelect = s_q.srcSelect;
  assign internalOscFreqSelect = s_q.freqSelect;

endmodule // fscs_fail_safe_clock_supervisor

// ### src/fscs_pkg.sv
// constants and types shared by the fail-safe clock supervisor
// ----------------------------------------------------------------
// Overview of operation
// [RQ1] monitoring and switchover happen only while the nonvolatile monitor enable bit is set.
// [RQ2] while monitoring is enabled the internal rc clock is requested to run without pause.
// [RQ3] the sample clock is the internal rc clock divided by 64.
// [RQ4] the monitor latch sets on each falling device clock edge and clears on each rising sample clock edge.
// [RQ5] a falling sample clock edge that finds the monitor latch still set declares a clock failure.
// [RQ6] a clock failure sets the oscillator fail flag in bit 7 of the second interrupt flag register.
// [RQ7] a failure moves the device clock to the internal oscillator while the oscillator control register is left as is.
// [RQ8] a failure resets the watchdog counter and its postscaler.
// [RQ9] only primary or secondary source failures are detected; the internal oscillator is not watched.
// [RQ10] the watchdog has its own divider, so disabling it never stops the rc clock while monitoring is on.
// [RQ11] software sets the internal frequency select right after reset, and before sleep for the wake-up speed.
// [RQ12] the fail-safe condition ends only on device reset or on entry into a power-managed mode.
// [RQ13] the oscillator fail flag stays set until software clears it and raises a request only when enabled.
// ----------------------------------------------------------------
package fscs_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the wishbone bus
  // ----------------------------------------------------------------
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_IRQ_FLAGS_2 = 5'h00;
  localparam logic [4:0] OFS_IRQ_ENABLE_2 = 5'h04;
  localparam logic [4:0] OFS_OSC_CONTROL = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_POWER_MANAGE = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_PM_ENTER = 0;
  localparam int POS_SRC_LO = 0;
  localparam int POS_SRC_HI = 1;
  localparam int POS_FREQ_LO = 4;
  localparam int POS_FREQ_HI = 6;
  localparam int BIT_ST_FAILSAFE = 0;
  localparam int BIT_ST_LATCH = 1;
  localparam int BIT_ST_ACTIVE = 2;
  localparam int BIT_ST_SAMPLE = 3;

  // ----------------------------------------------------------------
  // clock source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [1:0] SRC_INTERNAL = 2'h2;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [2:0] RST_FREQ = 3'h0;

  // ----------------------------------------------------------------
  // sample clock divider
  // ----------------------------------------------------------------
  localparam int SAMPLE_DIV = 64;
  localparam int DIV_W = $clog2(SAMPLE_DIV);
  localparam logic [DIV_W-1:0] DIV_HALF_LAST = DIV_W'(SAMPLE_DIV / 2 - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

  // ----------------------------------------------------------------
  // supervisor modes, gray coded along idle, watch, fail-safe
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSCS_IDLE = 2'b00,
    FSCS_WATCH = 2'b01,
    FSCS_FAILSAFE = 2'b11
  } fscs_mode_e;

  typedef struct packed {
    fscs_mode_e mode;
    logic [DIV_W-1:0] divCnt;
    logic rcPrev;
    logic devPrev;
    logic monLatch;
    logic oscFailFlag;
    logic oscFailEnable;
    logic [2:0] freqSelect;
    logic [1:0] srcSelect;
    logic ack;
    logic [31:0] rdData;
    logic clkSelInternal;
    logic irq;
    logic wdtReset;
    logic rcRun;
  } fscs_state_s;

endpackage

// ### testbench/fscs_ext_osc.sv
// behavioural external oscillator that feeds the monitored device clock
`timescale 1ns/1ps
module fscs_ext_osc (
  input wire logic clk,
  input wire logic run,
  output logic deviceClock
);
  logic [2:0] cnt_q = 3'h0;
  logic level_q = 1'b0;
  // a failed crystal stands at its last level; five cycles a half period keeps it slow
  always @(posedge clk) begin
    if (run) begin
      cnt_q <= (cnt_q == 3'h4) ? 3'h0 : cnt_q + 3'h1;
      if (cnt_q == 3'h4) begin
        level_q <= ~level_q;
      end
    end
  end
  assign deviceClock = level_q;
endmodule // fscs_ext_osc

// ### testbench/fscs_sva.sv
// port checker of the fail-safe clock supervisor
`timescale 1ns/1ps
module fscs_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic monitorEnableConfigBit,
  input wire logic watchdogEnable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic clkSelInternal,
  input wire logic watchdogReset,
  input wire logic rcRunRequest,
  input wire logic [1:0] oscSourceSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence failEntry;
    watchdogReset ##1 !watchdogReset;
  endsequence
  // a switch made by hardware, not by software selecting the internal source
  sequence hwSwitch;
    $rose(clkSelInternal) && !oscSourceSelect[1];
  endsequence
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("data outside ack");
  switch_wdt_a: assert property (hwSwitch |-> failEntry) else $error("no watchdog reset");
  wdt_cause_a: assert property (watchdogReset |-> $rose(clkSelInternal)) else $error("stray watchdog reset");
  enabled_only_a: assert property (hwSwitch |-> $past(monitorEnableConfigBit)) else $error("unwatched");
  ext_only_a: assert property ($rose(clkSelInternal) |-> !$past(oscSourceSelect[1]))
    else $error("internal seen");
  failsafe_hold_a: assert property (clkSelInternal && !wb_cyc_i |=> clkSelInternal)
    else $error("left early");
  rc_runs_a: assert property (monitorEnableConfigBit |=> rcRunRequest) else $error("rc stopped");
  rc_idle_a: assert property (!monitorEnableConfigBit && !watchdogEnable |=> !rcRunRequest)
    else $error("rc on");
endmodule // fscs_sva
bind fscs_fail_safe_clock_supervisor fscs_sva fscs_sva_inst (.clk(clk), .rst_b(rst_b),
  .monitorEnableConfigBit(monitorEnableConfigBit), .watchdogEnable(watchdogEnable), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clkSelInternal(clkSelInternal),
  .watchdogReset(watchdogReset), .rcRunRequest(rcRunRequest), .oscSourceSelect(oscSourceSelect));

// ### testbench/tb.sv
// self-checking bench of the fail-safe clock supervisor
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rcClk = 1'b0;
  logic devRun = 1'b1;
  logic devClk;
  logic monEn = 1'b0;
  logic wdtEn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, selInt, irq, wdtRst, rcRun, hit;
  logic [1:0] src;
  logic [2:0] freq;
  int fail_count = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  always @(posedge clk) rcClk <= ~rcClk;
  fscs_ext_osc fscs_ext_osc_inst (.clk(clk), .run(devRun), .deviceClock(devClk));
  fscs_fail_safe_clock_supervisor fscs_fail_safe_clock_supervisor_inst (.clk(clk), .rst_b(rst_b),
    .deviceClock(devClk), .internalRcClock(rcClk), .monitorEnableConfigBit(monEn), .watchdogEnable(wdtEn),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .clkSelInternal(selInt), .oscFailIrq(irq), .watchdogReset(wdtRst),
    .rcRunRequest(rcRun), .oscSourceSelect(src), .internalOscFreqSelect(freq));
  // ----------------------------------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    @(negedge clk);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  // one wait loop serves both directions; the slave is never assumed to answer in a fixed time
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask
  task automatic wait_fail(output logic found);
    found = 1'b0;
    repeat (400) begin
      @(negedge clk);
      if (wdtRst === 1'b1) found = 1'b1;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #160000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wr(fscs_pkg::OFS_OSC_CONTROL, 32'h00000050);
    chk({27'h0, freq, src}, 32'h00000014);
    rd(5'h14, 32'h00000000);
    // the primary source runs here, so only the missing enable keeps this quiet
    wait_fail(hit);
    chk({31'h0, hit}, 32'h00000000);
    chk({31'h0, rcRun}, 32'h00000000);
    wr(fscs_pkg::OFS_OSC_CONTROL, 32'h00000052);
    chk({27'h0, freq, src}, 32'h00000016);
    @(posedge clk) monEn <= 1'b1;
    wait_fail(hit);
    chk({30'h0, hit, selInt}, 32'h00000001);
    chk({31'h0, rcRun}, 32'h00000001);
    @(posedge clk) devRun <= 1'b0;
    // a full sample period lets the latch forget the last device edge
    repeat (160) @(posedge clk);
    wr(fscs_pkg::OFS_OSC_CONTROL, 32'h00000050);
    wait_fail(hit);
    chk({30'h0, hit, selInt}, 32'h00000000);
    @(posedge clk) devRun <= 1'b1;
    wait_fail(hit);
    chk({29'h0, hit, selInt, irq}, 32'h00000006);
    rd(fscs_pkg::OFS_IRQ_FLAGS_2, 32'h00000080);
    rd(fscs_pkg::OFS_OSC_CONTROL, 32'h00000050);
    wr(fscs_pkg::OFS_IRQ_ENABLE_2, 32'h00000080);
    chk({31'h0, irq}, 32'h00000001);
    wr(fscs_pkg::OFS_IRQ_FLAGS_2, 32'h00000080);
    rd(fscs_pkg::OFS_IRQ_FLAGS_2, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    wait_fail(hit);
    chk({30'h0, hit, selInt}, 32'h00000001);
    wr(fscs_pkg::OFS_POWER_MANAGE, 32'h00000001);
    chk({31'h0, selInt}, 32'h00000000);
    wait_fail(hit);
    chk({30'h0, hit, selInt}, 32'h00000003);
    // a device reset in mid-run must also end the fail-safe condition
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk({30'h0, selInt, irq}, 32'h00000000);
    rd(fscs_pkg::OFS_OSC_CONTROL, 32'h00000000);
    end_of_test();
  end
endmodule // tb
